// file: hw/ptef_fifo.sv
`timescale 1ns/100ps
module ptef_fifo
    import ptef_pkg::*;
#(
    parameter int WIDTH = PTEF_WORD_W,
    parameter int DEPTH = PTEF_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTEF_PTR_W-1:0] wr_ptr;
    logic [PTEF_PTR_W-1:0] rd_ptr;
    logic [PTEF_CNT_W-1:0] count;
    logic [PTEF_CNT_W-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + PTEF_CNT_ONE;
        end else if (pop && !push) begin
            next_count = count - PTEF_CNT_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags are flops so that full and empty never glitch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= PTEF_PTR_RESET;
            rd_ptr <= PTEF_PTR_RESET;
            count <= PTEF_CNT_RESET;
            in_ready <= 1'h0;
            out_valid <= 1'h0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTEF_PTR_LAST) ? PTEF_PTR_RESET : wr_ptr + 5'h01;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTEF_PTR_LAST) ? PTEF_PTR_RESET : rd_ptr + 5'h01;
            end
            count <= next_count;
            in_ready <= next_count != PTEF_CNT_FULL;
            out_valid <= next_count != PTEF_CNT_RESET;
        end
    end

    a_fifo_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
        count <= PTEF_CNT_FULL) else $error("fifo count beyond depth");

endmodule

// file: hw/ptef_flag.sv
`timescale 1ns/100ps
module ptef_flag
    import ptef_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic error_flag_clear_n,
    input wire logic sample,
    input wire logic point_p,
    output logic flag,
    output logic drive_low
);

    logic next_flag;

    // Sticky: a low flag survives every sample until cleared
    assign next_flag = sample ? (point_p && flag) : flag;

    // Clear acts without the clock and beats any sample
    always_ff @(posedge core_clk or negedge rst_b or negedge error_flag_clear_n) begin
        if (!rst_b || !error_flag_clear_n) begin
            flag <= PTEF_FLAG_RESET;
            drive_low <= PTEF_DRIVE_RESET;
        end else begin
            flag <= next_flag;
            drive_low <= !next_flag;
        end
    end

    a_flag_drain: assert property (@(posedge core_clk) disable iff (!rst_b)
        drive_low == !flag) else $error("drain does not follow flag");

endmodule

// file: hw/ptef_pkg.sv
package ptef_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and buffering
    localparam int PTEF_DATA_W = 8;
    localparam int PTEF_FIFO_DEPTH = 32;
    localparam int PTEF_PTR_W = 5;
    localparam int PTEF_CNT_W = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset, buffer limits and count step
    localparam logic PTEF_FLAG_RESET = 1'h1;
    localparam logic PTEF_DRIVE_RESET = 1'h0;
    localparam logic [PTEF_DATA_W-1:0] PTEF_DATA_RESET = 8'h00;
    localparam logic [PTEF_PTR_W-1:0] PTEF_PTR_RESET = 5'h00;
    localparam logic [PTEF_CNT_W-1:0] PTEF_CNT_RESET = 6'h00;
    localparam logic [PTEF_CNT_W-1:0] PTEF_CNT_FULL = 6'h20;
    localparam logic [PTEF_PTR_W-1:0] PTEF_PTR_LAST = 5'h1F;
    localparam logic [PTEF_CNT_W-1:0] PTEF_CNT_ONE = 6'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // Direction selected by the two enables
    typedef enum logic [1:0] {
        PTEF_A_TO_B,
        PTEF_B_TO_A,
        PTEF_ISOLATE,
        PTEF_A_TO_B_INV
    } ptef_mode_type;

    // One buffered A-to-B word with its generated parity
    typedef struct packed {
        logic inverted;
        logic parity;
        logic [PTEF_DATA_W-1:0] data;
    } ptef_word_type;

    localparam int PTEF_WORD_W = $bits(ptef_word_type);

    function automatic ptef_mode_type ptef_mode_of(input logic a_enable_n, input logic b_enable_n);
        ptef_mode_type m;
        m = PTEF_ISOLATE;
        unique case ({b_enable_n, a_enable_n})
            2'b01: m = PTEF_A_TO_B;
            2'b10: m = PTEF_B_TO_A;
            2'b11: m = PTEF_ISOLATE;
            2'b00: m = PTEF_A_TO_B_INV;
        endcase
        return m;
    endfunction

endpackage

// file: hw/ptef_top.sv
`timescale 1ns/100ps
// Functional notes
// - A to B with odd parity generated
// - B to A, clocked nine-bit check into flag
// - Clear low forces flag high asynchronously
// - Both enables high isolate the A, B and parity pins
// - Isolation samples inverted A parity into flag
// - Both enables low give inverted parity
// - Flag changes only on sampling edges or on clear
// - Flag low is sticky until cleared
// - Error flag is an open-drain output
// - Data passes true in both directions
module ptef_top
    import ptef_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic a_side_output_enable_n,
    input wire logic b_side_output_enable_n,
    input wire logic error_flag_clear_n,
    input wire logic [PTEF_DATA_W-1:0] a_in,
    output logic [PTEF_DATA_W-1:0] a_out,
    output logic a_oe,
    input wire logic [PTEF_DATA_W-1:0] b_in,
    output logic [PTEF_DATA_W-1:0] b_out,
    output logic b_oe,
    input wire logic parity_in,
    output logic parity_out,
    output logic parity_oe,
    output logic error_out,
    output logic error_oe,
    output logic a_ready,
    input wire logic b_accept
);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode

    ptef_mode_type mode;
    logic a_drive_mode;
    logic a_odd;
    logic b_odd;
    logic sample;
    logic point_p;

    assign mode = ptef_mode_of(a_side_output_enable_n, b_side_output_enable_n);
    assign a_drive_mode = (mode == PTEF_A_TO_B) || (mode == PTEF_A_TO_B_INV);
    assign a_odd = ^a_in;
    // Summation covers the parity pin along with the B bits
    assign b_odd = ^{parity_in, b_in};

    ////////////////////////////////////////////////////////////////////////////////
    // Parity generation into the buffer

    ptef_word_type gen_word;
    ptef_word_type head_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic pop;

    always_comb begin
        gen_word.data = a_in;
        gen_word.inverted = (mode == PTEF_A_TO_B_INV);
        if (mode == PTEF_A_TO_B_INV) begin
            gen_word.parity = a_odd;
        end else begin
            gen_word.parity = !a_odd;
        end
    end

    // Buffer decouples A capture from B drive; B side may stall
    ptef_fifo #(
        .WIDTH(PTEF_WORD_W),
        .DEPTH(PTEF_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(a_drive_mode),
        .in_ready(fifo_in_ready),
        .in_data(gen_word),
        .out_valid(fifo_out_valid),
        .out_ready(b_accept),
        .out_data(head_word)
    );

    assign pop = fifo_out_valid && b_accept;

    ////////////////////////////////////////////////////////////////////////////////
    // Error flag

    always_comb begin
        sample = 1'h0;
        point_p = 1'h1;
        unique case (mode)
            PTEF_B_TO_A: begin
                sample = 1'h1;
                point_p = b_odd;
            end
            PTEF_ISOLATE: begin
                sample = 1'h1;
                point_p = a_odd;
            end
            PTEF_A_TO_B, PTEF_A_TO_B_INV: begin
                sample = 1'h0;
                point_p = 1'h1;
            end
        endcase
    end

    logic flag;
    logic drive_low;

    ptef_flag u_flag (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .error_flag_clear_n(error_flag_clear_n),
        .sample(sample),
        .point_p(point_p),
        .flag(flag),
        .drive_low(drive_low)
    );

    // Open drain: only ever pulls low
    assign error_out = 1'h0;
    assign error_oe = drive_low;

    ////////////////////////////////////////////////////////////////////////////////
    // A side drive, true data from B

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            a_out <= PTEF_DATA_RESET;
            a_oe <= 1'h0;
        end else begin
            a_out <= b_in;
            a_oe <= (mode == PTEF_B_TO_A);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // B side drive from buffer head

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            b_out <= PTEF_DATA_RESET;
            parity_out <= 1'h0;
        end else if (pop) begin
            b_out <= head_word.data;
            parity_out <= head_word.parity;
        end
    end

    // Enables follow the pins one clock later; stale data may show until next pop
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            b_oe <= 1'h0;
            parity_oe <= 1'h0;
        end else begin
            b_oe <= a_drive_mode;
            parity_oe <= a_drive_mode;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            a_ready <= 1'h0;
        end else begin
            a_ready <= fifo_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_pop_normal;
        pop && !head_word.inverted;
    endsequence

    sequence s_pop_inverted;
        pop && head_word.inverted;
    endsequence

    sequence s_b_check_even;
        mode == PTEF_B_TO_A && !b_odd;
    endsequence

    sequence s_iso_even;
        mode == PTEF_ISOLATE && !a_odd;
    endsequence

    a_gen_parity: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        s_pop_normal |=> (parity_out == !(^b_out)))
        else $error("generated parity not odd");

    a_inv_parity: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        s_pop_inverted |=> (parity_out == (^b_out)))
        else $error("inverted parity wrong");

    a_check_even: assert property (@(posedge core_clk)
        disable iff (!rst_b || !error_flag_clear_n)
        s_b_check_even |=> !flag ##1 (!flag || !error_flag_clear_n))
        else $error("even nine-bit count did not set error");

    a_check_odd_keep: assert property (@(posedge core_clk)
        disable iff (!rst_b || !error_flag_clear_n)
        (mode == PTEF_B_TO_A && b_odd && flag) |=> flag)
        else $error("odd nine-bit count disturbed flag");

    a_iso_sample: assert property (@(posedge core_clk)
        disable iff (!rst_b || !error_flag_clear_n)
        s_iso_even |=> !flag)
        else $error("isolation even A count missed");

    a_clear_force: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !error_flag_clear_n |-> (flag && !error_oe))
        else $error("clear did not force flag high");

    a_flag_sticky: assert property (@(posedge core_clk)
        disable iff (!rst_b || !error_flag_clear_n)
        !flag |=> !flag)
        else $error("flag left low state without clear");

    a_flag_hold: assert property (@(posedge core_clk)
        disable iff (!rst_b || !error_flag_clear_n)
        a_drive_mode |=> $stable(flag))
        else $error("flag changed without sampling");

    a_isolate_pins: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (mode == PTEF_ISOLATE) |=> (!a_oe && !b_oe && !parity_oe))
        else $error("pins driven in isolation");

    a_true_data: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (mode == PTEF_B_TO_A) |=> (a_oe && a_out == $past(b_in)))
        else $error("B data not passed true to A");

    a_drain_open: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        error_oe |-> !error_out)
        else $error("error pin driven high");

    sequence s_iso_odd_clean;
        mode == PTEF_ISOLATE && a_odd && flag;
    endsequence

    a_iso_odd_keep: assert property (@(posedge core_clk)
        disable iff (!rst_b || !error_flag_clear_n)
        s_iso_odd_clean |=> flag)
        else $error("isolation odd A count disturbed flag");

    a_sample_low: assert property (@(posedge core_clk)
        disable iff (!rst_b || !error_flag_clear_n)
        (sample && !point_p) |=> !flag)
        else $error("low sample point did not set error");

    a_b_drive: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        a_drive_mode |=> (b_oe && parity_oe))
        else $error("B side not driven in A to B mode");

    a_a_release: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (mode != PTEF_B_TO_A) |=> !a_oe)
        else $error("A side driven outside B to A mode");

    // Both buses driven at once would fight the far side's drivers
    a_bus_exclusive: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !(a_oe && b_oe))
        else $error("A and B driven together");

    a_parity_pair: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        parity_oe == b_oe)
        else $error("parity pin enable split from B bus");

    a_inv_force: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        s_pop_inverted |=> !(^{parity_out, b_out}))
        else $error("inverted word does not carry even count");

    // Last popped word stays on the pins while the far side stalls
    a_b_hold: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !pop |=> $stable({parity_out, b_out}))
        else $error("B side changed without a pop");

    a_ready_follow: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        a_ready == $past(fifo_in_ready))
        else $error("room flag not one cycle behind buffer");

    ////////////////////////////////////////////////////////////////////////////////
    // Per-lane checks, so a swapped or inverted bit names itself

    for (genvar i = 0; i < PTEF_DATA_W; i++) begin : g_lane
        a_lane_true: assert property (@(posedge core_clk)
            disable iff (!rst_b)
            pop |=> (b_out[i] == $past(head_word.data[i])))
            else $error("B lane not passed true");
    end

endmodule

// file: testbench/parity_transceiver_error_flag_tb.sv
`timescale 1ns/100ps
module parity_transceiver_error_flag_tb;
    import ptef_pkg::*;
    logic core_clk, rst_b, a_en_n, b_en_n, clear_n, parity_bad, checking, exp_flag;
    logic [7:0] a_drv, b_data, a_in, a_out, b_in, b_out, last_b;
    logic a_oe, b_oe, parity_in, parity_out, parity_oe, error_out, error_oe, a_ready, b_accept;
    logic [1:0] accept_mode, last_mode;
    logic [8:0] exp_q[$];
    logic [8:0] exp_out;
    int failures, n_compared, fill;
    ////////////////////////////////////////////////////////////////////////////////
    assign a_in = a_oe ? a_out : a_drv;
    ptef_top u_ptef_top (.core_clk(core_clk), .rst_b(rst_b), .a_side_output_enable_n(a_en_n),
        .b_side_output_enable_n(b_en_n), .error_flag_clear_n(clear_n), .a_in(a_in), .a_out(a_out),
        .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe), .parity_in(parity_in),
        .parity_out(parity_out), .parity_oe(parity_oe), .error_out(error_out),
        .error_oe(error_oe), .a_ready(a_ready), .b_accept(b_accept));
    ptef_bus_partner u_ptef_bus_partner (.core_clk(core_clk), .b_out(b_out), .b_oe(b_oe),
        .parity_out(parity_out), .parity_oe(parity_oe), .b_data(b_data),
        .parity_bad(parity_bad), .accept_mode(accept_mode), .b_in(b_in),
        .parity_in(parity_in), .b_accept(b_accept));
    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Reference: flag, direction and buffered words, from the pin levels at each edge
    always @(posedge core_clk or negedge rst_b or negedge clear_n) begin
        if (!rst_b || !clear_n) begin
            exp_flag <= 1'h1;
        end else begin
            case ({b_en_n, a_en_n})
                2'h2: exp_flag <= exp_flag & (^{parity_in, b_in});
                2'h3: exp_flag <= exp_flag & (^a_in);
                default: exp_flag <= exp_flag;
            endcase
        end
    end
    // Clear touches only the flag; direction and buffer run on through it
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_mode <= 2'h3;
            exp_out <= 9'h000;
            exp_q.delete();
        end else begin
            last_mode <= {b_en_n, a_en_n};
            last_b <= b_in;
            fill = exp_q.size();
            // Head leaves on accept; a full buffer refuses the A word
            if (b_accept && fill != 0) exp_out <= exp_q.pop_front();
            if (!b_en_n && fill != PTEF_FIFO_DEPTH)
                exp_q.push_back({(a_en_n ? ~^a_in : ^a_in), a_in});
        end
    end
    // Half a cycle late so that an asynchronous clear has landed
    always @(negedge core_clk) begin
        #1;
        if (rst_b && checking) begin
            check(error_oe, !exp_flag);
            check(error_out, 1'h0);
            check(a_oe, last_mode == 2'h2);
            check(b_oe, !last_mode[1]);
            check(parity_oe, !last_mode[1]);
            if (last_mode == 2'h2) check(a_out, last_b);
            check({parity_out, b_out}, exp_out);
            // Level on the shared flag line, pull-up included
            check(error_oe ? error_out : 1'h1, exp_flag);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic drive(input logic [1:0] m, input logic [7:0] a, input logic [7:0] b,
            input logic bad, input logic clear);
        @(negedge core_clk);
        {b_en_n, a_en_n} <= m;
        a_drv <= a;
        b_data <= b;
        parity_bad <= bad;
        clear_n <= clear;
    endtask
    task automatic run(input int n, input logic [1:0] m, input logic [7:0] a,
            input logic [7:0] b, input logic bad, input logic clear);
        repeat (n) drive(m, a, b, bad, clear);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'h0;
        clear_n = 1'h1;
        {b_en_n, a_en_n} = 2'h3;
        a_drv = 8'h01;
        b_data = 8'h00;
        parity_bad = 1'h0;
        accept_mode = 2'h0;
        checking = 1'h1;
        failures = 0;
        n_compared = 0;
        void'($urandom(56));
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) rst_b <= 1'h1;
        run(1, 2'h3, 8'h01, 8'h00, 1'h0, 1'h0);
        run(1, 2'h3, 8'h01, 8'h00, 1'h0, 1'h1);
        check(a_ready, 1'h1);
        // Fill with the far side stalled, both parity kinds
        for (int i = 0; i < 32; i++) run(1, {1'h0, i[0]}, 8'(i) ^ 8'hA5, 8'h00, 1'h0, 1'h1);
        run(2, 2'h3, 8'h01, 8'h00, 1'h0, 1'h1);
        check(a_ready, 1'h0);
        accept_mode <= 2'h2;
        run(120, 2'h3, 8'h01, 8'h00, 1'h0, 1'h1);
        check(16'(exp_q.size()), 16'h0000);
        check(a_ready, 1'h1);
        // Flag: checking, stickiness, hold, clear, isolation sampling
        accept_mode <= 2'h1;
        run(3, 2'h2, 8'h00, 8'h5A, 1'h0, 1'h1);
        run(1, 2'h2, 8'h00, 8'h33, 1'h1, 1'h1);
        run(3, 2'h2, 8'h00, 8'h0F, 1'h0, 1'h1);
        run(1, 2'h1, 8'h11, 8'h00, 1'h0, 1'h1);
        run(1, 2'h0, 8'h22, 8'h00, 1'h0, 1'h1);
        run(2, 2'h2, 8'h00, 8'h01, 1'h1, 1'h0);
        run(2, 2'h3, 8'h03, 8'h00, 1'h0, 1'h1);
        run(1, 2'h3, 8'h03, 8'h00, 1'h0, 1'h0);
        run(2, 2'h3, 8'h07, 8'h00, 1'h0, 1'h1);
        // Random traffic, then drain
        accept_mode <= 2'h2;
        repeat (30) drive(2'($urandom_range(3)), 8'($urandom), 8'($urandom),
            $urandom_range(7) == 0, $urandom_range(15) != 0);
        accept_mode <= 2'h1;
        run(80, 2'h3, 8'h01, 8'h00, 1'h0, 1'h1);
        check(16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule

// file: testbench/ptef_bus_partner.sv
`timescale 1ns/100ps
module ptef_bus_partner
    import ptef_pkg::*;
(
    input wire logic core_clk,
    input wire logic [PTEF_DATA_W-1:0] b_out,
    input wire logic b_oe,
    input wire logic parity_out,
    input wire logic parity_oe,
    input wire logic [PTEF_DATA_W-1:0] b_data,
    input wire logic parity_bad,
    input wire logic [1:0] accept_mode,
    output logic [PTEF_DATA_W-1:0] b_in,
    output logic parity_in,
    output logic b_accept
);
    // Device owns the wire while it drives; otherwise odd parity unless told to break it
    assign b_in = b_oe ? b_out : b_data;
    assign parity_in = parity_oe ? parity_out : (~^b_data ^ parity_bad);
    initial b_accept = 1'h0;
    // Random stalls keep the buffer head waiting
    always @(negedge core_clk) begin
        case (accept_mode)
            2'h0: b_accept <= 1'h0;
            2'h1: b_accept <= 1'h1;
            default: b_accept <= 1'($urandom_range(1));
        endcase
    end
endmodule
